// file: dv/psag_addr_gen_asserts.sv
// checker for the program space address generator
`timescale 1ns/1ps
module psag_chk(input wire clk,resetn,fetch_req,data_req,data_we,table_read_op,table_write_op,
	input wire pm_req,pm_cfg,ds_req,remap_hit,cfg_write_blocked,input wire [7:0] table_page_value,remap_page_value,
	input wire [15:0] core_control_reg,data_ea,rd_data,input wire [22:0] fetch_pc,input wire [23:0] pm_addr,pm_rdata);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
wire tbl=table_read_op|table_write_op;
wire win=data_req&data_ea[15]&core_control_reg[2]&!tbl;
sequence s_win_rd; win&&!data_we; endsequence
tbl_addr_a: assert property(table_read_op|->pm_req&&pm_addr=={table_page_value,data_ea}&&pm_cfg==table_page_value[7])
	else $error("table address");
win_addr_a: assert property(win|->remap_hit&&pm_addr=={1'b0,remap_page_value,data_ea[14:1],1'b0})
	else $error("window address");
win_rd_a: assert property(s_win_rd ##1 1|=>{8'h00,rd_data}==($past(pm_rdata)&24'h00ffff))
	else $error("window data");
win_wr_a: assert property(win&&data_we|->!pm_req&&!ds_req) else $error("window write");
cfg_blk_a: assert property(table_write_op&&table_page_value[7]|->!pm_req&&cfg_write_blocked)
	else $error("cfg write");
tbl_wr_a: assert property(table_write_op&&!table_read_op&&!table_page_value[7]|->pm_req&&!cfg_write_blocked)
	else $error("table write");
win_hold_a: assert property(table_read_op&&data_req&&data_ea[15]|->!remap_hit) else $error("suspend");
ds_route_a: assert property(data_req&&!tbl&&!(data_ea[15]&&core_control_reg[2])|->ds_req&&!pm_req)
	else $error("data route");
fetch_addr_a: assert property(fetch_req&&!data_req&&!tbl|->pm_addr=={1'b0,fetch_pc[22:1],1'b0})
	else $error("fetch");
endmodule // psag_chk
bind psag_addr_gen psag_chk chk_u(.*);

// file: dv/psag_addr_gen_tb_top.sv
// bench for the program space address generator
`timescale 1ns/1ps
module program_space_address_gen_tb_top;
reg clk=0,resetn=0,fetch_req=0,data_req=0,data_we=0,table_read_op=0,table_write_op=0,table_high=0,table_byte=0;
reg [7:0] table_page_value=8'h12,remap_page_value=8'hb5;
reg [15:0] core_control_reg=16'h0004,data_ea=16'h0000,data_wdata=16'h5a3c;
reg [22:0] fetch_pc=23'h2abcd;
wire pm_req,pm_we,pm_cfg,pm_wr_high,ds_req,ds_we,remap_hit,cfg_write_blocked;
wire [1:0] pm_byte_en;
wire [23:0] pm_addr,pm_rdata;
wire [15:0] pm_wdata,ds_addr,ds_wdata,rd_data;
integer err_total=0,samples_checked=0;
initial forever #2.5 clk=~clk;
psag_addr_gen dut_u(.*);
psag_pm_model mem_u(.*);
function [23:0] pv(input [23:0] a);
	pv={a[7:0]^8'h5a,a[15:0]^16'hc3a5};
endfunction
task chk(input [63:0] n,input [31:0] s,e);
	begin
		samples_checked=samples_checked+1;
		if(s!==e) begin
			err_total=err_total+1;
			$display("CHECK FAILED %0s exp %h seen %h",n,e,s);
		end
	end
endtask
task op(input [6:0] c,input [15:0] a);
	begin
		@(negedge clk);
		{table_read_op,table_write_op,table_high,table_byte,data_req,data_we,fetch_req}=c;
		data_ea=a;
		#1;
	end
endtask
task rd(input [23:0] e);
	begin
		op(7'h00,data_ea);
		@(posedge clk);
		#1 chk("rd_data",rd_data,e);
	end
endtask
task test_done;
	begin
		$display("checks %0d mismatches %0d",samples_checked,err_total);
		if(err_total==0&&samples_checked>0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	end
endtask
initial begin
	#100000 err_total=err_total+1;
	test_done;
end
initial begin
	repeat(8) @(posedge clk);
	@(negedge clk) resetn=1;
	op(7'h40,16'h3457);
	chk("taddr",{pm_cfg,pm_addr[22:0]},24'h123457);
	rd(pv(24'h123457)&24'h00ffff);
	op(7'h48,16'h3457);
	chk("ben1",pm_byte_en,32'h2);
	rd((pv(24'h123457)>>8)&24'h0000ff);
	op(7'h48,16'h3456);
	chk("ben0",pm_byte_en,32'h1);
	rd(pv(24'h123456)&24'h0000ff);
	op(7'h30,16'h2222);
	chk("twr",{pm_req,pm_we,pm_wr_high,cfg_write_blocked,pm_byte_en,pm_addr},30'h3b122222);
	chk("twdata",pm_wdata,32'h5a3c);
	@(negedge clk) table_page_value=8'h81;
	op(7'h50,16'h0010);
	chk("tcfg",pm_cfg,24'h1);
	rd(pv(24'h810010)>>16);
	op(7'h58,16'h0011);
	chk("ben",pm_byte_en,24'h2);
	rd(24'h0);
	op(7'h20,16'h0010);
	chk("blk",{pm_req,cfg_write_blocked},24'h1);
	$display("table test done");
	op(7'h04,16'hc00b);
	chk("waddr",{remap_hit,pm_addr},25'h15ac00a);
	rd(pv(24'h5ac00a)&24'h00ffff);
	op(7'h06,16'hc00b);
	chk("wwr",{pm_req,ds_req},24'h0);
	op(7'h44,16'hc00b);
	chk("susp",{remap_hit,pm_addr[22:0]},24'h01c00b);
	@(negedge clk) core_control_reg=16'hfffb;
	op(7'h04,16'hc00b);
	chk("off",{pm_req,ds_req},24'h1);
	op(7'h06,16'hc00b);
	chk("dsw",{ds_req,ds_we,pm_req,ds_addr},19'h6c00b);
	chk("dswdata",ds_wdata,32'h5a3c);
	op(7'h01,16'h0000);
	chk("fetch",pm_addr,24'h02abcc);
	$display("remap test done");
	@(negedge clk) resetn=0;
	#1 chk("rst",rd_data,32'h0);
	@(negedge clk) resetn=1;
	core_control_reg=16'h0004;
	op(7'h04,16'h8002);
	chk("waddr2",{remap_hit,pm_addr},32'h15a8002);
	rd(pv(24'h5a8002)&24'h00ffff);
	$display("reset test done");
	test_done;
end
endmodule // program_space_address_gen_tb_top

// file: dv/psag_pm_model.sv
// program memory partner model
`timescale 1ns/1ps
module psag_pm_model(input wire clk,input wire pm_req,input wire [23:0] pm_addr,output reg [23:0] pm_rdata);
initial pm_rdata=24'h000000;
// idle cycles invert, so stale data passes only after an even number of them
always @(posedge clk) pm_rdata<=pm_req?{pm_addr[7:0]^8'h5a,pm_addr[15:0]^16'hc3a5}:~pm_rdata;
endmodule // psag_pm_model

// file: hw/psag_addr_gen.v
// program space address generator: table and remap window paths onto program memory
`timescale 1ns/1ps
`include "psag_map.vh"
module psag_addr_gen (
	// clock and reset
	input wire clk,
	input wire resetn,
	// page and control values from the core
	input wire [`PSAG_PAGE_W-1:0] table_page_value,
	input wire [`PSAG_PAGE_W-1:0] remap_page_value,
	input wire [`PSAG_CTRL_W-1:0] core_control_reg,
	// instruction fetch
	input wire fetch_req,
	input wire [22:0] fetch_pc,
	// data space access from the address generator
	input wire data_req,
	input wire data_we,
	input wire [`PSAG_DADDR_W-1:0] data_ea,
	input wire [`PSAG_WORD_W-1:0] data_wdata,
	// table instructions
	input wire table_read_op,
	input wire table_write_op,
	input wire table_high,
	input wire table_byte,
	// program memory side
	output reg pm_req,
	output reg pm_we,
	output reg pm_cfg,
	output reg [`PSAG_PADDR_W-1:0] pm_addr,
	output reg [`PSAG_WORD_W-1:0] pm_wdata,
	output reg pm_wr_high,
	output reg [1:0] pm_byte_en,
	input wire [`PSAG_PADDR_W-1:0] pm_rdata,
	// data space routing and return
	output reg ds_req,
	output reg ds_we,
	output reg [`PSAG_DADDR_W-1:0] ds_addr,
	output reg [`PSAG_WORD_W-1:0] ds_wdata,
	output reg remap_hit,
	output reg cfg_write_blocked,
	output wire [`PSAG_WORD_W-1:0] rd_data
);

	// route codes, one hot: table outranks window, window outranks data, data outranks fetch
	localparam [4:0] route_idle = 5'h01;
	localparam [4:0] route_table = 5'h02;
	localparam [4:0] route_remap = 5'h04;
	localparam [4:0] route_data = 5'h08;
	localparam [4:0] route_fetch = 5'h10;

	wire table_op;
	wire remap_en;
	wire remap_sel;
	wire tbl_cfg;
	wire tbl_wr_ok;
	wire [`PSAG_PADDR_W-1:0] tbl_addr;
	wire [`PSAG_EA_WIN_MSB-1:0] remap_low;
	wire [`PSAG_PADDR_W-1:0] remap_addr;
	wire [`PSAG_PADDR_W-1:0] fetch_addr;
	wire [`PSAG_LANES-1:0] tbl_byte_en;
	wire [`PSAG_BYTE_W-1:0] pm_upper;
	wire [`PSAG_BYTE_W-1:0] pm_lane1;
	wire [`PSAG_BYTE_W-1:0] pm_lane0;
	reg [4:0] route;
	reg rd_pending;
	reg rd_high;
	reg rd_byte;
	reg rd_bsel;
	reg next_rd_pending;
	reg next_rd_high;
	reg next_rd_byte;
	reg [`PSAG_WORD_W-1:0] sel_data;

	assign table_op = table_read_op | table_write_op;
	assign remap_en = core_control_reg[`PSAG_CTRL_REMAP_BIT];
	// table has priority; the window is suspended meanwhile
	assign remap_sel = data_req & data_ea[`PSAG_EA_MSB] & remap_en & ~table_op;
	assign tbl_cfg = table_page_value[`PSAG_CFG_BIT];
	assign tbl_wr_ok = table_write_op & ~tbl_cfg;
	// no alignment forced: table addressing is byte granular
	assign tbl_addr = {table_page_value, data_ea};
	// ea bit 15 is always set in the window, so it is dropped
	assign remap_low = data_ea[`PSAG_EA_WIN_MSB:`PSAG_ALIGN_BIT+1];
	// bit 23 zero keeps the window out of configuration space; page bit 0 lands on bit 15
	assign remap_addr = {1'h0, remap_page_value, remap_low, 1'h0};
	assign fetch_addr = {1'h0, fetch_pc[`PSAG_PC_W-1:`PSAG_ALIGN_BIT+1], 1'h0};

	// a byte sized table op opens only the lane named by ea bit 0
	genvar lane;
	generate
		for (lane = 0; lane < `PSAG_LANES; lane = lane + 1) begin : g_lane
			assign tbl_byte_en[lane] = ~table_byte | (data_ea[`PSAG_BSEL_BIT] == (lane == 1));
		end
	endgenerate

	always @* begin
		if (table_op) begin
			route = route_table;
		end else if (remap_sel) begin
			route = route_remap;
		end else if (data_req) begin
			route = route_data;
		end else if (fetch_req) begin
			route = route_fetch;
		end else begin
			route = route_idle;
		end
	end

	always @* begin
		pm_req = 1'h0;
		pm_we = 1'h0;
		pm_cfg = 1'h0;
		pm_addr = {`PSAG_PADDR_W{1'h0}};
		pm_wdata = data_wdata;
		pm_wr_high = 1'h0;
		pm_byte_en = {`PSAG_LANES{1'h0}};
		ds_req = 1'h0;
		ds_we = 1'h0;
		ds_addr = data_ea;
		ds_wdata = data_wdata;
		remap_hit = 1'h0;
		cfg_write_blocked = 1'h0;
		next_rd_pending = 1'h0;
		next_rd_high = 1'h0;
		next_rd_byte = 1'h0;
		case (route)
			route_table: begin
				pm_addr = tbl_addr;
				pm_cfg = tbl_cfg;
				pm_wr_high = table_high;
				pm_byte_en = tbl_byte_en;
				next_rd_high = table_high;
				next_rd_byte = table_byte;
				if (table_read_op) begin
					pm_req = 1'h1;
					next_rd_pending = 1'h1;
				end else if (tbl_wr_ok) begin
					pm_req = 1'h1;
					pm_we = 1'h1;
				end else begin
					cfg_write_blocked = 1'h1;
				end
			end
			route_remap: begin
				remap_hit = 1'h1;
				pm_addr = remap_addr;
				pm_byte_en = `PSAG_LANES_ALL;
				// writes through the window are dropped, never turned into data writes
				pm_req = ~data_we;
				next_rd_pending = ~data_we;
			end
			route_data: begin
				ds_req = 1'h1;
				ds_we = data_we;
			end
			route_fetch: begin
				// fetch words go to the core directly, rd_data is left alone
				pm_req = 1'h1;
				pm_addr = fetch_addr;
				pm_byte_en = `PSAG_LANES_ALL;
			end
			default: begin
				pm_req = 1'h0;
			end
		endcase
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_pending <= 1'h0;
			rd_high <= 1'h0;
			rd_byte <= 1'h0;
			rd_bsel <= 1'h0;
		end else begin
			rd_pending <= next_rd_pending;
			rd_high <= next_rd_high;
			rd_byte <= next_rd_byte;
			// taken every cycle; only steers a pending byte read
			rd_bsel <= data_ea[`PSAG_BSEL_BIT];
		end
	end

	assign pm_upper = pm_rdata[`PSAG_PADDR_W-1:`PSAG_HIGH_LSB];
	assign pm_lane1 = pm_rdata[`PSAG_WORD_W-1:`PSAG_BYTE_W];
	assign pm_lane0 = pm_rdata[`PSAG_BYTE_W-1:0];

	// upper phantom byte always reads zero
	always @* begin
		if (rd_high) begin
			if (rd_byte && rd_bsel) begin
				sel_data = `PSAG_WORD_ZERO;
			end else begin
				sel_data = {`PSAG_BYTE_ZERO, pm_upper};
			end
		end else if (rd_byte) begin
			sel_data = {`PSAG_BYTE_ZERO, rd_bsel ? pm_lane1 : pm_lane0};
		end else begin
			sel_data = {pm_lane1, pm_lane0};
		end
	end

	// memory answers one edge after the request, the result is held one edge later
	psag_fetch_reg u_rd_reg (
		.clk(clk),
		.resetn(resetn),
		.load(rd_pending),
		.din(sel_data),
		.dout(rd_data)
	);
endmodule // psag_addr_gen

// file: hw/psag_fetch_reg.v
// output register stage for read data returned to the core
`timescale 1ns/1ps
`include "psag_map.vh"
module psag_fetch_reg (
	// clock and reset
	input wire clk,
	input wire resetn,
	// capture side
	input wire load,
	input wire [15:0] din,
	// registered output
	output reg [15:0] dout
);
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dout <= `PSAG_WORD_ZERO;
		end else if (load) begin
			dout <= din;
		end
	end
endmodule // psag_fetch_reg

// file: hw/psag_map.vh
// address map, field positions and encodings for the program space address generator
`ifndef PSAG_MAP_VH
`define PSAG_MAP_VH
`define PSAG_PADDR_W 24
`define PSAG_DADDR_W 16
`define PSAG_PAGE_W 8
`define PSAG_WORD_W 16
`define PSAG_HIGH_W 8
`define PSAG_CFG_BIT 7
`define PSAG_EA_MSB 15
`define PSAG_CTRL_REMAP_BIT 2
`define PSAG_CTRL_W 16
`define PSAG_CTRL_RESET 16'h0000
`define PSAG_PAGE_RESET 8'h00
`define PSAG_CFG_ID_RESET 24'h000000
`define PSAG_PC_W 23
`define PSAG_BYTE_W 8
`define PSAG_LANES 2
`define PSAG_LANES_ALL 2'h3
`define PSAG_BSEL_BIT 0
`define PSAG_ALIGN_BIT 0
`define PSAG_EA_WIN_MSB 14
`define PSAG_HIGH_LSB 16
`define PSAG_BYTE_ZERO 8'h00
`define PSAG_WORD_ZERO 16'h0000
`endif
